// ### rtl/rfc_defines.svh
// Constants for the radio front end control block
// Assumes a 20 MHz system clock and a byte-wide register port
`ifndef RFC_DEFINES_SVH
`define RFC_DEFINES_SVH
// ==========================================================
// Register offsets
`define RFC_OFS_CMD        12'h800
`define RFC_OFS_ARG0       12'h801
`define RFC_OFS_ARG1       12'h802
`define RFC_OFS_ARG2       12'h803
`define RFC_OFS_STATUS     12'h804
`define RFC_OFS_RECEIVED_LEVEL_INDICATOR       12'h805
`define RFC_OFS_GAIN_NOW   12'h806
`define RFC_OFS_MODE_B     12'h891
`define RFC_OFS_LOOP_EN    12'h895
`define RFC_OFS_MAN_LEVEL  12'h89e
`define RFC_OFS_MAN_SEL    12'h89f
// ==========================================================
// Command codes
`define RFC_CMD_TX         8'h83
`define RFC_CMD_RX         8'h82
`define RFC_CMD_PWR        8'h8e
`define RFC_CMD_TONE       8'hd1
`define RFC_CMD_PATTERN    8'hd2
`define RFC_CMD_FREQ       8'h86
`define RFC_CMD_SYNTH      8'hc1
`define RFC_CMD_REG        8'h96
`define RFC_CMD_STANDBY    8'h80
`define RFC_CMD_PKT_STAT   8'h1d
// ==========================================================
// Field positions and reset values
`define RFC_HS_MSB         7
`define RFC_HS_LSB         6
`define RFC_HS_ON          2'h3
`define RFC_SEL_BIT        7
`define RFC_LOOP_BIT       0
`define RFC_RST_LOOP_EN    8'h01
`define RFC_RST_MAN_LEVEL  8'h0d
`define RFC_RST_FREQ       24'hb89d89
`define RFC_GAIN_MAX       4'hd
`define RFC_GAIN_LP_MAX    4'ha
// ==========================================================
// Timing, power and packet length
`define RFC_CLK_MHZ        20
`define RFC_RAMP_MIN_US    2
`define RFC_RAMP_MAX_US    20
`define RFC_PWR_MAX        8'h1f
`define RFC_SYNTH_LOCK_CYC 8'h10
`define RFC_PKT_BITS       16'h0100
`endif

// ### rtl/rfc_pkg.sv
// Types for the radio front end control block
// Assumes rfc_defines.svh is on the include path
package rfc_pkg;
  typedef enum logic [2:0] {
    RFC_SLEEP, RFC_STBY_RC, RFC_STBY_XO, RFC_SYNTH, RFC_RAMP, RFC_TX, RFC_RX
  } rfc_state_t;
  typedef enum logic [1:0] {RFC_TXM_PKT, RFC_TXM_TONE, RFC_TXM_PAT} rfc_txmode_t;
  typedef struct packed {
    logic [7:0] power;
    logic [7:0] ramp_us;
  } rfc_pa_cfg_t;
  typedef struct packed {
    logic       tx_on;
    logic       rx_on;
    logic       synth_on;
    logic       buck_on;
    logic       hs_mode;
    logic [3:0] lna_gain;
  } rfc_fe_ctl_t;
endpackage

// ### rtl/rfc_frontend_ctrl.sv
// Radio front end control: command interpreter, timeouts, gain selection
// Assumes a host command port on i_clk and synchronous buffer/modem inputs
// ==========================================================
`include "rfc_defines.svh"

module rfc_frontend_ctrl
  import rfc_pkg::*;
#(
  parameter int TICK_W = 16
) (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic [11:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  input  wire logic        i_pkt_bit,
  input  wire logic        i_pkt_bit_last,
  input  wire logic        i_rx_detect,
  input  wire logic [7:0]  i_rx_level,
  input  wire logic [3:0]  i_auto_gain,
  input  wire logic        i_slow_tick,
  input  wire logic        i_wake_req,
  input  wire logic        i_host_active,
  output logic             o_fast_rc_on,
  output logic             o_slow_rc_on,
  output logic             o_xtal_on,
  output logic             o_tx_bit,
  output logic             o_tx_bit_valid,
  output logic             o_pkt_bit_req,
  output logic             o_prefilter_on,
  output logic      [7:0]  o_pa_level,
  output logic      [7:0]  o_pa_dac,
  output logic      [23:0] o_carrier_word,
  output rfc_fe_ctl_t      o_fe_ctl
);

  localparam logic [15:0] CYC_PER_US = 16'(`RFC_CLK_MHZ);

  // ==========================================================
  // Synchronisers for pin-level inputs
  logic [1:0] host_sync_ff;
  logic [1:0] wake_sync_ff;
  logic [1:0] tick_sync_ff;
  logic       tick_prev_ff;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      host_sync_ff <= 2'h0;
      wake_sync_ff <= 2'h0;
      tick_sync_ff <= 2'h0;
      tick_prev_ff <= 1'b0;
    end else begin
      host_sync_ff <= {host_sync_ff[0], i_host_active};
      wake_sync_ff <= {wake_sync_ff[0], i_wake_req};
      tick_sync_ff <= {tick_sync_ff[0], i_slow_tick};
      tick_prev_ff <= tick_sync_ff[1];
    end
  end
  wire tick_pulse = tick_sync_ff[1] & ~tick_prev_ff;

  // ==========================================================
  // Register file
  logic [7:0]    cmd_arg0_ff, cmd_arg1_ff, cmd_arg2_ff;
  logic [7:0]    mode_b_ff, loop_en_ff, man_level_ff, man_sel_ff;
  logic [7:0]    received_level_indicator_ff;
  rfc_pa_cfg_t   pa_cfg_ff;
  logic [23:0]   freq_ff;
  logic          buck_sel_ff, prefilt_ff, xtal_sel_ff, slow_wake_ff;
  rfc_state_t    state_ff;
  rfc_txmode_t   txmode_ff;
  wire           cmd_go = i_wr && (i_addr == `RFC_OFS_CMD);

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cmd_arg0_ff  <= 8'h00;
      cmd_arg1_ff  <= 8'h00;
      cmd_arg2_ff  <= 8'h00;
      mode_b_ff    <= 8'h00;
      loop_en_ff   <= `RFC_RST_LOOP_EN;
      man_level_ff <= `RFC_RST_MAN_LEVEL;
      man_sel_ff   <= 8'h00;
    end else if (i_wr) begin
      case (i_addr)
        `RFC_OFS_ARG0:      cmd_arg0_ff  <= i_wdata;
        `RFC_OFS_ARG1:      cmd_arg1_ff  <= i_wdata;
        `RFC_OFS_ARG2:      cmd_arg2_ff  <= i_wdata;
        `RFC_OFS_MODE_B:    mode_b_ff    <= i_wdata;
        `RFC_OFS_LOOP_EN:   loop_en_ff   <= i_wdata;
        `RFC_OFS_MAN_LEVEL: man_level_ff <= i_wdata;
        `RFC_OFS_MAN_SEL:   man_sel_ff   <= i_wdata;
        default: ;
      endcase
    end
  end

  // Configuration commands latch their arguments
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pa_cfg_ff    <= '{power: 8'h00, ramp_us: 8'(`RFC_RAMP_MIN_US)};
      freq_ff      <= `RFC_RST_FREQ;
      buck_sel_ff  <= 1'b0;
      prefilt_ff   <= 1'b0;
      xtal_sel_ff  <= 1'b0;
      slow_wake_ff <= 1'b0;
    end else if (cmd_go) begin
      case (i_wdata)
        `RFC_CMD_PWR: begin
          pa_cfg_ff.power   <= (cmd_arg0_ff > `RFC_PWR_MAX) ? `RFC_PWR_MAX : cmd_arg0_ff;
          pa_cfg_ff.ramp_us <= (cmd_arg1_ff < 8'(`RFC_RAMP_MIN_US)) ? 8'(`RFC_RAMP_MIN_US) :
                               (cmd_arg1_ff > 8'(`RFC_RAMP_MAX_US)) ? 8'(`RFC_RAMP_MAX_US) : cmd_arg1_ff;
          prefilt_ff        <= cmd_arg2_ff[0];
        end
        `RFC_CMD_FREQ: freq_ff <= {cmd_arg2_ff, cmd_arg1_ff, cmd_arg0_ff};
        `RFC_CMD_REG: begin
          if (state_ff == RFC_STBY_RC) begin
            buck_sel_ff <= cmd_arg0_ff[0];
          end
        end
        `RFC_CMD_STANDBY: begin
          xtal_sel_ff  <= cmd_arg0_ff[0];
          slow_wake_ff <= cmd_arg0_ff[1];
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Mode sequencer with timeout and ramp timers
  rfc_state_t         target_ff;
  logic [TICK_W-1:0]  tick_cnt_ff;
  logic [1:0]         tick_base_ff;
  logic [15:0]        cyc_cnt_ff;
  logic               timeout_on_ff;
  wire tx_rx_cmd = cmd_go && (i_wdata == `RFC_CMD_TX || i_wdata == `RFC_CMD_RX ||
                   i_wdata == `RFC_CMD_TONE || i_wdata == `RFC_CMD_PATTERN);

  function automatic logic [15:0] base_cycles(input logic [1:0] b);
    case (b)
      2'h0:    base_cycles = CYC_PER_US;
      2'h1:    base_cycles = 16'(CYC_PER_US * 16'h0010);
      2'h2:    base_cycles = 16'(CYC_PER_US * 16'h0040);
      default: base_cycles = 16'(CYC_PER_US * 16'h0100);
    endcase
  endfunction

  wire base_done = (cyc_cnt_ff == 16'h0001);
  wire timed_out = timeout_on_ff && base_done && (tick_cnt_ff == TICK_W'(1));

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_ff      <= RFC_STBY_RC;
      target_ff     <= RFC_STBY_RC;
      txmode_ff     <= RFC_TXM_PKT;
      tick_cnt_ff   <= '0;
      tick_base_ff  <= 2'h0;
      cyc_cnt_ff    <= 16'h0000;
      timeout_on_ff <= 1'b0;
    end else begin
      case (state_ff)
        RFC_SLEEP: begin
          if (host_sync_ff[1] || wake_sync_ff[1] || (slow_wake_ff && tick_pulse)) begin
            state_ff <= RFC_STBY_RC;
          end
        end
        RFC_STBY_RC, RFC_STBY_XO: begin
          if (tx_rx_cmd) begin
            // Synth step before TX or RX
            state_ff      <= RFC_SYNTH;
            target_ff     <= (i_wdata == `RFC_CMD_RX) ? RFC_RX : RFC_TX;
            txmode_ff     <= (i_wdata == `RFC_CMD_TONE) ? RFC_TXM_TONE :
                             (i_wdata == `RFC_CMD_PATTERN) ? RFC_TXM_PAT : RFC_TXM_PKT;
            tick_base_ff  <= cmd_arg0_ff[1:0];
            tick_cnt_ff   <= TICK_W'({cmd_arg2_ff, cmd_arg1_ff});
            timeout_on_ff <= ({cmd_arg2_ff, cmd_arg1_ff} != 16'h0000) &&
                             (i_wdata == `RFC_CMD_TX || i_wdata == `RFC_CMD_RX);
            cyc_cnt_ff    <= 16'(`RFC_SYNTH_LOCK_CYC);
          end else if (cmd_go && i_wdata == `RFC_CMD_SYNTH) begin
            state_ff   <= RFC_SYNTH;
            target_ff  <= RFC_SYNTH;
            cyc_cnt_ff <= 16'(`RFC_SYNTH_LOCK_CYC);
          end else if (cmd_go && i_wdata == `RFC_CMD_STANDBY) begin
            state_ff <= cmd_arg0_ff[0] ? RFC_STBY_XO : RFC_STBY_RC;
          end
        end
        RFC_SYNTH: begin
          if (cyc_cnt_ff > 16'h0001) begin
            cyc_cnt_ff <= cyc_cnt_ff - 16'h0001;
          end else if (target_ff == RFC_RX) begin
            state_ff   <= RFC_RX;
            cyc_cnt_ff <= base_cycles(tick_base_ff);
          end else if (target_ff == RFC_TX) begin
            state_ff   <= RFC_RAMP;
            cyc_cnt_ff <= 16'(pa_cfg_ff.ramp_us * CYC_PER_US);
          end else if (cmd_go && i_wdata == `RFC_CMD_STANDBY) begin
            state_ff <= RFC_STBY_RC;
          end
        end
        RFC_RAMP: begin
          if (cyc_cnt_ff > 16'h0001) begin
            cyc_cnt_ff <= cyc_cnt_ff - 16'h0001;
          end else begin
            state_ff   <= RFC_TX;
            cyc_cnt_ff <= base_cycles(tick_base_ff);
          end
        end
        RFC_TX, RFC_RX: begin
          cyc_cnt_ff <= base_done ? base_cycles(tick_base_ff) : cyc_cnt_ff - 16'h0001;
          if (base_done && tick_cnt_ff != '0) begin
            tick_cnt_ff <= tick_cnt_ff - TICK_W'(1);
          end
          if (timed_out || (state_ff == RFC_TX && txmode_ff == RFC_TXM_PKT && i_pkt_bit_last) ||
              (cmd_go && i_wdata == `RFC_CMD_STANDBY)) begin
            state_ff      <= RFC_STBY_RC;
            timeout_on_ff <= 1'b0;
          end
        end
        default: state_ff <= RFC_STBY_RC;
      endcase
    end
  end

  // ==========================================================
  // Transmit data path
  logic pat_ff;
  logic tx_bit_ff, tx_valid_ff;
  wire  in_tx = (state_ff == RFC_TX);
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pat_ff      <= 1'b0;
      tx_bit_ff   <= 1'b0;
      tx_valid_ff <= 1'b0;
    end else begin
      pat_ff      <= in_tx ? ~pat_ff : 1'b0;
      tx_valid_ff <= in_tx && (txmode_ff != RFC_TXM_TONE);
      case (txmode_ff)
        RFC_TXM_PKT:  tx_bit_ff <= i_pkt_bit;
        RFC_TXM_PAT:  tx_bit_ff <= pat_ff;
        default:      tx_bit_ff <= 1'b0;
      endcase
    end
  end
  assign o_pkt_bit_req = in_tx && (txmode_ff == RFC_TXM_PKT);

  // ==========================================================
  // Receive level and gain selection
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      received_level_indicator_ff <= 8'h00;
    end else if (state_ff == RFC_RX && i_rx_detect) begin
      received_level_indicator_ff <= i_rx_level;
    end
  end

  wire hs_mode  = (mode_b_ff[`RFC_HS_MSB:`RFC_HS_LSB] == `RFC_HS_ON);
  // Manual only when select bit set and loop enable bit clear
  wire manual   = man_sel_ff[`RFC_SEL_BIT] && !loop_en_ff[`RFC_LOOP_BIT];
  logic [3:0] gain_raw, gain_sel;
  always_comb begin
    // Code 13 is max gain; table in analog
    if (manual) begin
      gain_raw = (man_level_ff[3:0] == 4'h0) ? 4'h1 :
                 (man_level_ff[3:0] > `RFC_GAIN_MAX) ? `RFC_GAIN_MAX : man_level_ff[3:0];
    end else begin
      gain_raw = i_auto_gain;
    end
    // Low power hides top three steps
    gain_sel = (!hs_mode && gain_raw > `RFC_GAIN_LP_MAX) ? `RFC_GAIN_LP_MAX : gain_raw;
  end

  // ==========================================================
  // Read port, data one cycle later
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `RFC_OFS_ARG0:      o_rdata <= cmd_arg0_ff;
        `RFC_OFS_ARG1:      o_rdata <= cmd_arg1_ff;
        `RFC_OFS_ARG2:      o_rdata <= cmd_arg2_ff;
        `RFC_OFS_STATUS:    o_rdata <= {buck_sel_ff, xtal_sel_ff, 2'(txmode_ff), 1'b0, 3'(state_ff)};
        `RFC_OFS_RECEIVED_LEVEL_INDICATOR:      o_rdata <= received_level_indicator_ff;
        `RFC_OFS_GAIN_NOW:  o_rdata <= {4'h0, gain_sel};
        `RFC_OFS_MODE_B:    o_rdata <= mode_b_ff;
        `RFC_OFS_LOOP_EN:   o_rdata <= loop_en_ff;
        `RFC_OFS_MAN_LEVEL: o_rdata <= man_level_ff;
        `RFC_OFS_MAN_SEL:   o_rdata <= man_sel_ff;
        default:            o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // ==========================================================
  // Front end and clock controls
  logic [7:0] dac_ff;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dac_ff <= 8'h00;
    end else if (state_ff == RFC_RAMP) begin
      // Linear ramp of PA supply reference
      // Top forced on last ramp cycle; short ramps end in one step
      dac_ff <= (dac_ff == 8'hff || cyc_cnt_ff <= 16'h0001) ? 8'hff : dac_ff + 8'h01;
    end else begin
      dac_ff <= in_tx ? 8'hff : 8'h00;
    end
  end

  wire active = (state_ff == RFC_STBY_XO) || (state_ff == RFC_SYNTH) || (state_ff == RFC_RAMP) ||
                in_tx || (state_ff == RFC_RX);
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_fe_ctl       <= '0;
      o_fast_rc_on   <= 1'b1;
      o_slow_rc_on   <= 1'b0;
      o_xtal_on      <= 1'b0;
      o_pa_level     <= 8'h00;
      o_carrier_word <= `RFC_RST_FREQ;
      o_prefilter_on <= 1'b0;
      o_tx_bit       <= 1'b0;
      o_tx_bit_valid <= 1'b0;
      o_pa_dac       <= 8'h00;
    end else begin
      o_fe_ctl.tx_on    <= in_tx;
      o_fe_ctl.rx_on    <= (state_ff == RFC_RX);
      o_fe_ctl.synth_on <= active && (state_ff != RFC_STBY_XO);
      o_fe_ctl.buck_on  <= buck_sel_ff && active;
      o_fe_ctl.hs_mode  <= hs_mode;
      o_fe_ctl.lna_gain <= gain_sel;
      // Fast RC on with host traffic
      o_fast_rc_on      <= host_sync_ff[1] || (state_ff != RFC_SLEEP);
      // Slow RC kept for sleep wake
      o_slow_rc_on      <= (state_ff == RFC_SLEEP) && slow_wake_ff;
      o_xtal_on         <= (state_ff != RFC_SLEEP) && (xtal_sel_ff || (active && state_ff != RFC_STBY_XO)
                           || state_ff == RFC_STBY_XO);
      // Level code is -18 dBm plus power
      o_pa_level        <= pa_cfg_ff.power;
      o_carrier_word    <= freq_ff;
      o_prefilter_on    <= prefilt_ff && in_tx;
      o_tx_bit          <= tx_bit_ff;
      o_tx_bit_valid    <= tx_valid_ff;
      o_pa_dac          <= dac_ff;
    end
  end

endmodule // rfc_frontend_ctrl

// ### verif/rfc_buf_model.sv
// Model of the packet buffer and modem beside the control block
// Assumes design outputs are sampled on i_clk rising edges
module rfc_buf_model (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_pkt_bit_req,
  input  wire logic        i_rx_on,
  input  wire logic [15:0] i_n_bits,
  input  wire logic [7:0]  i_level,
  output logic             o_pkt_bit,
  output logic             o_pkt_bit_last,
  output logic             o_rx_detect,
  output logic      [7:0]  o_rx_level
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  lfsr_ff;
  logic [15:0] cnt_ff;
  logic [3:0]  dly_ff;
  // ==========================================================
  // Packet source
  // last pulse beside final bit
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lfsr_ff        <= 8'h5a;
      cnt_ff         <= 16'h0000;
      o_pkt_bit_last <= 1'b0;
    end else if (i_pkt_bit_req) begin
      lfsr_ff        <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
      cnt_ff         <= cnt_ff + 16'h0001;
      o_pkt_bit_last <= (cnt_ff + 16'h0002 == i_n_bits);
    end else begin
      lfsr_ff        <= ~lfsr_ff;
      cnt_ff         <= 16'h0000;
      o_pkt_bit_last <= 1'b0;
    end
  end
  // Idle line toggles so a stale bit never looks valid
  assign o_pkt_bit = lfsr_ff[0];
  // ==========================================================
  // Receive detect, once per receive window
  // level beside detect pulse
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dly_ff      <= 4'h0;
      o_rx_detect <= 1'b0;
      o_rx_level  <= 8'h00;
    end else begin
      dly_ff      <= i_rx_on ? ((dly_ff == 4'hf) ? dly_ff : dly_ff + 4'h1) : 4'h0;
      o_rx_detect <= i_rx_on && (dly_ff == 4'h8);
      o_rx_level  <= (i_rx_on && (dly_ff == 4'h8)) ? i_level : ~i_level;
    end
  end
endmodule // rfc_buf_model

// ### verif/rfc_frontend_ctrl_props.sv
// Checker for the radio front end control block
// Assumes it sees only the top module ports, bound below
module rfc_frontend_ctrl_chk
  import rfc_pkg::*;
#(
  parameter int TICK_W = 16
) (
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_rd,
  input wire logic [7:0]  o_rdata,
  input wire logic        i_pkt_bit,
  input wire logic        i_pkt_bit_last,
  input wire logic        i_host_active,
  input wire logic        o_pkt_bit_req,
  input wire logic        o_tx_bit,
  input wire logic        o_tx_bit_valid,
  input wire logic        o_prefilter_on,
  input wire logic        o_fast_rc_on,
  input wire logic [7:0]  o_pa_level,
  input wire logic [7:0]  o_pa_dac,
  input wire rfc_fe_ctl_t o_fe_ctl
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // ==========================================================
  // Assertions
  rdata_idle_zero_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside answer cycle");
  tx_bit_follow_a: assert property ($past(o_pkt_bit_req, 2) && o_tx_bit_valid |-> o_tx_bit == $past(i_pkt_bit, 2))
    else $error("transmit bit does not follow buffer bit");
  tx_end_last_a: assert property (o_pkt_bit_req && i_pkt_bit_last |-> ##[1:3] !o_fe_ctl.tx_on)
    else $error("transmit did not end after last bit");
  pa_ramp_done_a: assert property (o_fe_ctl.tx_on |-> o_pa_dac == 8'hff)
    else $error("amplifier reference not at top in transmit");
  pa_level_cap_a: assert property (o_pa_level <= 8'h1f)
    else $error("power parameter above ceiling");
  gain_lp_clamp_a: assert property (!o_fe_ctl.hs_mode |-> o_fe_ctl.lna_gain <= 4'ha)
    else $error("top gain steps used in low power mode");
  gain_code_max_a: assert property (o_fe_ctl.lna_gain <= 4'hd)
    else $error("gain code above maximum");
  half_duplex_a: assert property (!(o_fe_ctl.tx_on && o_fe_ctl.rx_on))
    else $error("transmit and receive both on");
  prefilter_tx_a: assert property (o_prefilter_on |-> o_fe_ctl.tx_on || $past(o_fe_ctl.tx_on))
    else $error("prefilter on outside transmit");
  host_fast_rc_a: assert property ($rose(i_host_active) |-> ##[1:4] o_fast_rc_on)
    else $error("fast oscillator off during host traffic");
  tx_seen_c: cover property ($rose(o_fe_ctl.tx_on));
  rx_seen_c: cover property ($rose(o_fe_ctl.rx_on));
  hs_seen_c: cover property ($rose(o_fe_ctl.hs_mode));
endmodule // rfc_frontend_ctrl_chk

bind rfc_frontend_ctrl rfc_frontend_ctrl_chk #(.TICK_W(TICK_W)) chk_u (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_rd(i_rd), .o_rdata(o_rdata), .i_pkt_bit(i_pkt_bit),
  .i_pkt_bit_last(i_pkt_bit_last), .i_host_active(i_host_active), .o_pkt_bit_req(o_pkt_bit_req),
  .o_tx_bit(o_tx_bit), .o_tx_bit_valid(o_tx_bit_valid), .o_prefilter_on(o_prefilter_on),
  .o_fast_rc_on(o_fast_rc_on), .o_pa_level(o_pa_level), .o_pa_dac(o_pa_dac), .o_fe_ctl(o_fe_ctl));

// ### verif/testbench.sv
// Self-checking bench for the radio front end control block
// Assumes the register port answers reads one cycle later
`include "rfc_defines.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module testbench
  import rfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk = 1'b0, i_sys_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_slow_tick = 1'b0, i_host_active = 1'b0;
  logic [11:0] i_addr = 12'h000;
  logic [7:0]  i_wdata = 8'h00, i_level = 8'h00, d, b1, i_rx_level;
  logic [3:0]  i_auto_gain = 4'h1;
  logic [15:0] i_n_bits = 16'hffff;
  logic        i_pkt_bit, i_pkt_bit_last, i_rx_detect, o_fast_rc_on, o_slow_rc_on, o_xtal_on;
  logic        o_tx_bit, o_tx_bit_valid, o_pkt_bit_req, o_prefilter_on;
  logic [7:0]  o_rdata, o_pa_level, o_pa_dac;
  logic [23:0] o_carrier_word, w;
  rfc_fe_ctl_t o_fe_ctl;
  int          n_mismatch = 0, checks_done = 0, n, m, e;
  int          ramps [4] = '{0, 2, 20, 25};
  always #25 i_clk = ~i_clk;
  always @(posedge i_clk) i_slow_tick <= ($urandom_range(155) == 0) ? ~i_slow_tick : i_slow_tick;
  rfc_frontend_ctrl #(.TICK_W(16)) dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pkt_bit(i_pkt_bit), .i_pkt_bit_last(i_pkt_bit_last),
    .i_rx_detect(i_rx_detect), .i_rx_level(i_rx_level), .i_auto_gain(i_auto_gain), .i_slow_tick(i_slow_tick),
    .i_wake_req(1'b0), .i_host_active(i_host_active), .o_fast_rc_on(o_fast_rc_on), .o_slow_rc_on(o_slow_rc_on),
    .o_xtal_on(o_xtal_on), .o_tx_bit(o_tx_bit), .o_tx_bit_valid(o_tx_bit_valid), .o_pkt_bit_req(o_pkt_bit_req),
    .o_prefilter_on(o_prefilter_on), .o_pa_level(o_pa_level), .o_pa_dac(o_pa_dac),
    .o_carrier_word(o_carrier_word), .o_fe_ctl(o_fe_ctl));
  rfc_buf_model buf_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_pkt_bit_req(o_pkt_bit_req),
    .i_rx_on(o_fe_ctl.rx_on), .i_n_bits(i_n_bits), .i_level(i_level), .o_pkt_bit(i_pkt_bit),
    .o_pkt_bit_last(i_pkt_bit_last), .o_rx_detect(i_rx_detect), .o_rx_level(i_rx_level));
  // ==========================================================
  // Bus tasks and expectations
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask
  // Arguments first, code last; two settle cycles before checking
  task automatic cmd(input logic [7:0] c, input logic [7:0] a0, input logic [7:0] a1, input logic [7:0] a2);
    wr(`RFC_OFS_ARG0, a0);
    wr(`RFC_OFS_ARG1, a1);
    wr(`RFC_OFS_ARG2, a2);
    wr(`RFC_OFS_CMD, c);
    repeat (2) @(negedge i_clk);
  endtask
  // Bounded wait on transmit or receive enable
  task automatic wait_on(input bit rx, input logic v, output int k);
    for (k = 0; k < 2000 && (rx ? o_fe_ctl.rx_on : o_fe_ctl.tx_on) !== v; k++) @(posedge i_clk) #1;
    `CHK("wait_limit", 1'b1, k < 2000)
  endtask
  function automatic logic [3:0] exp_gain(input logic [3:0] c, input logic hs);
    logic [3:0] g;
    g = (c == 4'h0) ? 4'h1 : (c > 4'hd) ? 4'hd : c;
    return (!hs && g > 4'ha) ? 4'ha : g;
  endfunction
  function automatic int exp_ramp(input int r);
    return (r < 2) ? 2 : (r > 20) ? 20 : r;
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #(40000 * 50);
    n_mismatch++;
    $display("watchdog expired");
    end_of_test();
  end
  // ==========================================================
  // Tests
  initial begin
    void'($urandom(32'h4e17));
    repeat (16) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd(`RFC_OFS_LOOP_EN, d); `CHK("loop_en", 8'h01, d)
    rd(`RFC_OFS_MAN_LEVEL, d); `CHK("man_level", 8'h0d, d)
    rd(`RFC_OFS_STATUS, d); `CHK("state", 3'h1, d[2:0])
    rd(12'h123, d); `CHK("unmapped", 8'h00, d)
    `CHK("carrier_rst", 24'hb89d89, o_carrier_word)
    `CHK("fast_rc", 1'b1, o_fast_rc_on)
    `CHK("slow_rc", 1'b0, o_slow_rc_on)
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      w = $urandom;
      cmd(`RFC_CMD_FREQ, w[7:0], w[15:8], w[23:16]);
      `CHK("carrier", w, o_carrier_word)
    end
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 8'h00 : (i == 1) ? 8'h1f : 8'($urandom_range(31));
      cmd(`RFC_CMD_PWR, d, 8'h02, 8'h00);
      `CHK("pa_level", d, o_pa_level)
    end
    $display("test config done");
    foreach (ramps[i]) begin
      cmd(`RFC_CMD_PWR, 8'h10, 8'(ramps[i]), 8'h01);
      i_n_bits <= 16'd40;
      cmd(`RFC_CMD_TX, 8'h00, 8'h00, 8'h00);
      wait_on(1'b0, 1'b1, n);
      e = 16 + exp_ramp(ramps[i]) * 20;
      `CHK("ramp_time", 1'b1, n >= e - 3 && n <= e + 3)
      repeat (2) @(posedge i_clk) #1;
      `CHK("prefilter", 1'b1, o_prefilter_on)
      wait_on(1'b0, 1'b0, m);
      `CHK("tx_len", 1'b1, m >= 34 && m <= 44)
      rd(`RFC_OFS_STATUS, d); `CHK("tx_state", 3'h1, d[2:0])
    end
    i_n_bits <= 16'hffff;
    cmd(`RFC_CMD_TX, 8'h00, 8'h03, 8'h00);
    wait_on(1'b0, 1'b1, n);
    wait_on(1'b0, 1'b0, m);
    `CHK("tx_timeout", 1'b1, m >= 56 && m <= 64)
    i_level <= 8'($urandom);
    cmd(`RFC_CMD_RX, 8'h00, 8'h05, 8'h00);
    wait_on(1'b1, 1'b1, n);
    wait_on(1'b1, 1'b0, m);
    `CHK("rx_timeout", 1'b1, m >= 96 && m <= 104)
    rd(`RFC_OFS_RECEIVED_LEVEL_INDICATOR, d); `CHK("rx_level", i_level, d)
    $display("test tx rx done");
    cmd(`RFC_CMD_TONE, 8'h00, 8'h00, 8'h00);
    wait_on(1'b0, 1'b1, n);
    `CHK("tone_valid", 1'b0, o_tx_bit_valid)
    rd(`RFC_OFS_STATUS, d); `CHK("tone_mode", 2'h1, d[5:4])
    cmd(`RFC_CMD_STANDBY, 8'h00, 8'h00, 8'h00);
    cmd(`RFC_CMD_PATTERN, 8'h00, 8'h00, 8'h00);
    wait_on(1'b0, 1'b1, n);
    repeat (3) @(posedge i_clk) #1;
    b1[0] = o_tx_bit;
    @(posedge i_clk) #1;
    `CHK("pattern", ~b1[0], o_tx_bit)
    cmd(`RFC_CMD_STANDBY, 8'h00, 8'h00, 8'h00);
    cmd(`RFC_CMD_REG, 8'h01, 8'h00, 8'h00);
    `CHK("buck_rc", 1'b0, o_fe_ctl.buck_on)
    cmd(`RFC_CMD_STANDBY, 8'h01, 8'h00, 8'h00);
    `CHK("xtal", 1'b1, o_xtal_on)
    `CHK("buck_xo", 1'b1, o_fe_ctl.buck_on)
    cmd(`RFC_CMD_SYNTH, 8'h00, 8'h00, 8'h00);
    `CHK("synth", 1'b1, o_fe_ctl.synth_on)
    cmd(`RFC_CMD_REG, 8'h00, 8'h00, 8'h00);
    rd(`RFC_OFS_STATUS, d); `CHK("reg_refused", 1'b1, d[7])
    cmd(`RFC_CMD_STANDBY, 8'h00, 8'h00, 8'h00);
    rd(`RFC_OFS_STATUS, d); `CHK("stby_state", 3'h1, d[2:0])
    cmd(`RFC_CMD_REG, 8'h00, 8'h00, 8'h00);
    $display("test modes done");
    wr(`RFC_OFS_MAN_SEL, 8'h80);
    wr(`RFC_OFS_LOOP_EN, 8'h00);
    for (int hs = 0; hs < 2; hs++) begin
      wr(`RFC_OFS_MODE_B, hs ? 8'hc0 : 8'h00);
      for (int c = 1; c < 14; c++) begin
        wr(`RFC_OFS_MAN_LEVEL, 8'(c));
        rd(`RFC_OFS_GAIN_NOW, d); `CHK("man_gain", exp_gain(4'(c), hs[0]), d[3:0])
      end
      `CHK("hs_mode", hs[0], o_fe_ctl.hs_mode)
    end
    wr(`RFC_OFS_LOOP_EN, 8'h01);
    for (int i = 0; i < 4; i++) begin
      @(posedge i_clk);
      i_auto_gain <= 4'($urandom_range(13, 1));
      rd(`RFC_OFS_GAIN_NOW, d); `CHK("auto_gain", exp_gain(i_auto_gain, 1'b1), d[3:0])
    end
    @(posedge i_clk);
    i_host_active <= 1'b1;
    repeat (5) @(posedge i_clk) #1;
    `CHK("host_rc", 1'b1, o_fast_rc_on)
    $display("test gain done");
    end_of_test();
  end
endmodule // testbench
